// ==== hw/olp_pkg.sv ====
// package for the last-page one-time-programmable write controller
package olp_pkg;

  // special data memory addresses of the three registers
  localparam logic [7:0] OLP_ADDR_CTRL = 8'h2c;
  localparam logic [7:0] OLP_ADDR_DATA_LOW = 8'h2d;
  localparam logic [7:0] OLP_ADDR_DATA_HIGH = 8'h2e;

  // control register field positions
  localparam int OLP_BIT_WRITE_ENABLE = 3;
  localparam int OLP_BIT_WRITE_TRIGGER = 2;

  // reset values
  localparam logic [7:0] OLP_DATA_RESET = 8'h00;
  localparam logic OLP_CTRL_BIT_RESET = 1'b0;

  // program memory geometry: last page upper address bits
  localparam int OLP_PM_ADDR_W = 12;
  localparam logic [3:0] OLP_LAST_PAGE_HIGH = 4'hf;

  // timing: write time and clock period in ns, counts in system clock cycles
  localparam int OLP_TABLE_READ_CYCLES = 2;
  localparam int OLP_WRITE_TIME_NS = 1000;
  localparam int OLP_CLK_PERIOD_NS = 10;
  localparam int OLP_WRITE_CYCLES = OLP_WRITE_TIME_NS / OLP_CLK_PERIOD_NS;

  // special register bus access from the cpu
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } olp_sfr_req_type;

  // program memory array port
  typedef struct packed {
    logic we;
    logic re;
    logic [OLP_PM_ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } olp_pm_req_type;

  typedef enum logic [2:0] {
    OLP_IDLE = 3'b001,
    OLP_WRITE = 3'b010,
    OLP_READ = 3'b100
  } olp_state_type;

endpackage

// ==== hw/olp_cycle_counter.sv ====
// down counter that times the write cycle and the table read
`timescale 1ns/1ps
module olp_cycle_counter #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  // status
  output logic o_done
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic done;
  } olp_cnt_state_type;

  olp_cnt_state_type state_q, state_d;

  always_comb begin
    state_d = state_q;
    state_d.done = 1'b0;
    if (i_load) begin
      state_d.cnt = i_count;
    end else if (state_q.cnt != '0) begin
      state_d.cnt = state_q.cnt - WIDTH'(1);
      if (state_q.cnt == WIDTH'(1)) begin
        state_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_done = state_q.done;
endmodule

// ==== hw/olp_otp_last_page_program_ctrl.sv ====
// self-programming controller for the last page of program memory
// Notes on behaviour
// - writes only reach addresses inside the last program memory page; cells are write-once.
// - software loads data low, data high and table pointer low before a write.
// - control bit 3 enables writing; hardware clears it when the write ends.
// - control bit 2 starts a write; hardware clears it at the end.
// - setting the trigger is ignored unless enable was already set.
// - enable and trigger set by one write do not start a write.
// - trigger must follow the enable write in the very next instruction cycle.
// - cpu is stalled for the whole write cycle, then resumes.
// - control bits 7..4 and 1..0 read as zero.
// - entering idle or sleep during a write makes the write fail.
// - last page table read returns low byte to cpu, high byte to latch.
// - registers sit at 2ch, 2dh, 2eh; data registers reset to zero.
// - every table read is timed by two system clock cycles of the counter.
`timescale 1ns/1ps
module olp_otp_last_page_program_ctrl #(
  parameter int WRITE_CYCLES = olp_pkg::OLP_WRITE_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // cpu special register access, one access per instruction cycle strobe
  input wire logic i_instr_cycle,
  input wire olp_pkg::olp_sfr_req_type i_sfr,
  output logic [7:0] o_sfr_rdata,
  // table pointer low and last-page table read request
  input wire logic [7:0] i_table_ptr_low,
  input wire logic i_table_read,
  output logic [7:0] o_table_low_byte,
  output logic [7:0] o_table_high_latch,
  output logic o_table_valid,
  // power mode entry
  input wire logic i_low_power_entry,
  // cpu stall and status
  output logic o_cpu_stall,
  output logic o_write_failed,
  // program memory array
  output olp_pkg::olp_pm_req_type o_pm,
  input wire logic [15:0] i_pm_rdata
);
  import olp_pkg::*;

  localparam int CW = 16;

  typedef struct packed {
    olp_state_type st;
    logic wen;
    logic wtrig;
    logic wen_fresh;
    logic [7:0] dlow;
    logic [7:0] dhigh;
    logic [7:0] rdata;
    logic [7:0] tlow;
    logic [7:0] thigh;
    logic tvalid;
    logic stall;
    logic failed;
    logic [CW-1:0] cnt_val;
    logic cnt_load;
    olp_pm_req_type pm;
  } olp_ctrl_state_type;

  olp_ctrl_state_type state_q, state_d;
  logic cnt_done;

  olp_cycle_counter #(
    .WIDTH(CW)
  ) u_counter (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(state_q.cnt_load),
    .i_count(state_q.cnt_val),
    .o_done(cnt_done)
  );

  logic wr_ctrl;
  logic [7:0] ctrl_view;
  assign wr_ctrl = i_sfr.wr && i_sfr.addr == OLP_ADDR_CTRL && i_instr_cycle;
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[OLP_BIT_WRITE_ENABLE] = state_q.wen;
    ctrl_view[OLP_BIT_WRITE_TRIGGER] = state_q.wtrig;
  end

  // register decode; a write only acts on the instruction strobe
  logic wr_data_low;
  logic wr_data_high;
  logic enable_req;
  logic trigger_req;
  logic start_write;
  logic start_read;
  logic write_done;
  logic read_done;
  logic power_cut;
  logic [7:0] rd_mux;
  logic [OLP_PM_ADDR_W-1:0] pm_target;

  assign wr_data_low = i_sfr.wr && i_instr_cycle && i_sfr.addr == OLP_ADDR_DATA_LOW;
  assign wr_data_high = i_sfr.wr && i_instr_cycle && i_sfr.addr == OLP_ADDR_DATA_HIGH;
  assign enable_req = wr_ctrl && i_sfr.wdata[OLP_BIT_WRITE_ENABLE];
  assign trigger_req = wr_ctrl && i_sfr.wdata[OLP_BIT_WRITE_TRIGGER];
  // the trigger counts only right after an enable-only write and while enable stays high,
  // so only a write carrying both bits, made inside that window, can start the array
  assign start_write = trigger_req && enable_req
    && state_q.wen && state_q.wen_fresh;
  // a control write in the same cycle takes precedence over a table read request
  assign start_read = !wr_ctrl && i_table_read;
  assign write_done = state_q.st == OLP_WRITE && cnt_done;
  assign read_done = state_q.st == OLP_READ && cnt_done;
  assign power_cut = state_q.st == OLP_WRITE && i_low_power_entry;
  // the page bits are fixed, so software can never aim below the last page
  assign pm_target = {OLP_LAST_PAGE_HIGH, i_table_ptr_low};

  // empty slots read as zero, like any unused special register address
  always_comb begin
    rd_mux = 8'h00;
    case (i_sfr.addr)
      OLP_ADDR_CTRL: rd_mux = ctrl_view;
      OLP_ADDR_DATA_LOW: rd_mux = state_q.dlow;
      OLP_ADDR_DATA_HIGH: rd_mux = state_q.dhigh;
      default: rd_mux = 8'h00;
    endcase
  end

  // next state; every field not named below keeps its value
  always_comb begin
    state_d = state_q;
    state_d.cnt_load = 1'b0;
    state_d.tvalid = 1'b0;
    state_d.pm.we = 1'b0;
    state_d.pm.re = 1'b0;
    // an enable write lives only until the next instruction cycle
    if (i_instr_cycle) begin
      state_d.wen_fresh = 1'b0;
    end
    if (i_sfr.rd) begin
      state_d.rdata = rd_mux;
    end
    case (state_q.st)
      OLP_IDLE: begin
        // data registers only move while idle, so a running write keeps its word
        if (wr_data_low) begin
          state_d.dlow = i_sfr.wdata;
        end
        if (wr_data_high) begin
          state_d.dhigh = i_sfr.wdata;
        end
        if (wr_ctrl) begin
          state_d.wen = i_sfr.wdata[OLP_BIT_WRITE_ENABLE];
          // setting enable on its own opens a one-instruction window for the trigger
          state_d.wen_fresh = enable_req && !trigger_req;
        end
        if (start_write) begin
          state_d.wtrig = 1'b1;
          state_d.stall = 1'b1;
          state_d.failed = 1'b0;
          state_d.st = OLP_WRITE;
          state_d.pm.we = 1'b1;
          state_d.pm.addr = pm_target;
          state_d.pm.wdata = {state_q.dhigh, state_q.dlow};
          state_d.cnt_val = CW'(WRITE_CYCLES);
          state_d.cnt_load = 1'b1;
        end else if (start_read) begin
          // the address goes out with the strobe; the pointer may move afterwards
          state_d.st = OLP_READ;
          state_d.pm.re = 1'b1;
          state_d.pm.addr = pm_target;
          state_d.cnt_val = CW'(OLP_TABLE_READ_CYCLES);
          state_d.cnt_load = 1'b1;
        end
      end

      OLP_WRITE: begin
        // the flag stays until the next start so software can still see a spoiled word
        if (power_cut) begin
          state_d.failed = 1'b1;
        end
        if (write_done) begin
          state_d.wen = OLP_CTRL_BIT_RESET;
          state_d.wtrig = OLP_CTRL_BIT_RESET;
          state_d.stall = 1'b0;
          state_d.st = OLP_IDLE;
        end
      end

      OLP_READ: begin
        // array data are taken when the count runs out, never earlier
        if (read_done) begin
          state_d.tlow = i_pm_rdata[7:0];
          state_d.thigh = i_pm_rdata[15:8];
          state_d.tvalid = 1'b1;
          state_d.st = OLP_IDLE;
        end
      end

      default: state_d.st = OLP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= '0;
      state_q.st <= OLP_IDLE;
      state_q.dlow <= OLP_DATA_RESET;
      state_q.dhigh <= OLP_DATA_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // every output is a flop of the state struct
  assign o_sfr_rdata = state_q.rdata;
  assign o_table_low_byte = state_q.tlow;
  assign o_table_high_latch = state_q.thigh;
  assign o_table_valid = state_q.tvalid;
  assign o_cpu_stall = state_q.stall;
  assign o_write_failed = state_q.failed;
  assign o_pm = state_q.pm;
endmodule

// ==== test/olp_pm_model.sv ====
// behavioural last page of the one-time-programmable array
`timescale 1ns/1ps
module olp_pm_model #(
  parameter logic [15:0] BLANK = 16'hffff
) (
  input wire logic i_clk,
  input wire olp_pkg::olp_pm_req_type i_pm,
  output logic [15:0] o_rdata
);
  import olp_pkg::*;
  logic [15:0] mem [256];
  logic [7:0] ra = 8'h00;
  logic [2:0] vis = 3'h0;
  initial foreach (mem[k]) mem[k] = BLANK;
  always @(posedge i_clk) begin
    vis <= vis >> 1;
    if (i_pm.we && mem[i_pm.addr[7:0]] === BLANK) mem[i_pm.addr[7:0]] <= i_pm.wdata;
    if (i_pm.re) begin
      ra <= i_pm.addr[7:0];
      vis <= 3'h7;
    end
  end
  // outside a read the bus shows the inverse so stale data never passes
  assign o_rdata = (vis != 3'h0) ? mem[ra] : ~mem[ra];
endmodule

// ==== test/olp_monitor.sv ====
// assertions on the last-page programming controller ports
`timescale 1ns/1ps
module olp_monitor #(
  parameter int WRITE_CYCLES = 5
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_instr_cycle,
  input wire olp_pkg::olp_sfr_req_type i_sfr,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_table_valid,
  input wire logic o_cpu_stall,
  input wire olp_pkg::olp_pm_req_type o_pm
);
  import olp_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [15:0] run_q;
  logic arm_q;
  wire ctrl_wr = i_instr_cycle && i_sfr.wr && i_sfr.addr == OLP_ADDR_CTRL;
  wire ctrl_rd = i_sfr.rd && i_sfr.addr == OLP_ADDR_CTRL;
  always_ff @(posedge i_clk) begin
    run_q <= (i_sys_rst || !o_cpu_stall) ? 16'h0000 : run_q + 16'h0001;
    // the armed flag lives until the next instruction, like the design's window
    if (i_sys_rst) begin
      arm_q <= 1'b0;
    end else if (i_instr_cycle) begin
      arm_q <= ctrl_wr && i_sfr.wdata[3:2] == 2'b10 && !o_cpu_stall;
    end
  end
  sequence s_arm;
    ctrl_wr && i_sfr.wdata[3:2] == 2'b10 && !o_cpu_stall;
  endsequence
  sequence s_fire;
    ctrl_wr && i_sfr.wdata[3:2] == 2'b11;
  endsequence
  a_write_starts: assert property (s_arm ##1 s_fire |=> o_pm.we && o_cpu_stall)
    else $error("write not started");
  a_lone_trigger: assert property ((!arm_q && !o_cpu_stall) ##0 s_fire |=> !o_pm.we)
    else $error("write started without fresh enable");
  a_stall_bound: assert property (run_q <= WRITE_CYCLES + 2)
    else $error("stall too long");
  a_stall_ends: assert property (o_cpu_stall && run_q == WRITE_CYCLES + 1 |=> !o_cpu_stall)
    else $error("stall did not end");
  a_we_pulse: assert property (o_pm.we |=> !o_pm.we && o_cpu_stall)
    else $error("write strobe not a pulse");
  a_page_addr: assert property (o_pm.we || o_pm.re |-> o_pm.addr[11:8] == OLP_LAST_PAGE_HIGH)
    else $error("address outside last page");
  a_read_two: assert property (o_pm.re |-> ##4 o_table_valid)
    else $error("table read length wrong");
  a_unimpl_zero: assert property (ctrl_rd |=> (o_sfr_rdata & 8'hf3) == 8'h00)
    else $error("unused control bits not zero");
  a_busy_ctrl: assert property (ctrl_rd && o_cpu_stall |=> o_sfr_rdata == 8'h0c)
    else $error("control bits wrong during write");
endmodule
bind olp_otp_last_page_program_ctrl olp_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.i_clk,
  .i_sys_rst, .i_instr_cycle, .i_sfr, .o_sfr_rdata, .o_table_valid, .o_cpu_stall, .o_pm);

// ==== test/otp_last_page_program_ctrl_test.sv ====
// self-checking bench for the last-page programming controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module otp_last_page_program_ctrl_test;
  import olp_pkg::*;
  localparam int WC = 5;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_instr_cycle = 1'b1;
  logic i_table_read = 1'b0, i_low_power_entry = 1'b0;
  olp_sfr_req_type i_sfr = '0;
  logic [7:0] i_table_ptr_low = 8'h00, o_sfr_rdata, o_table_low_byte, o_table_high_latch, ad;
  logic o_table_valid, o_cpu_stall, o_write_failed;
  olp_pm_req_type o_pm;
  logic [15:0] i_pm_rdata, word, wd;
  logic [11:0] wa;
  int failures = 0, checked = 0, wes = 0, w0, n;
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_pm.we === 1'b1) begin
    wes++;
    wa = o_pm.addr;
    wd = o_pm.wdata;
  end
  olp_otp_last_page_program_ctrl #(.WRITE_CYCLES(WC)) dut (.i_clk, .i_sys_rst, .i_instr_cycle,
    .i_sfr, .o_sfr_rdata, .i_table_ptr_low, .i_table_read, .o_table_low_byte,
    .o_table_high_latch, .o_table_valid, .i_low_power_entry, .o_cpu_stall, .o_write_failed,
    .o_pm, .i_pm_rdata);
  olp_pm_model pm (.i_clk, .i_pm(o_pm), .o_rdata(i_pm_rdata));
  function automatic logic [11:0] pm_addr(input logic [7:0] a);
    return {OLP_LAST_PAGE_HIGH, a};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_sfr = '{1'b1, 1'b0, a, d};
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_clk);
    i_sfr = '0;
    `CHK("register read", e, o_sfr_rdata)
  endtask
  task automatic prog(input logic [7:0] a, input logic [15:0] w, input logic lp,
      input logic gap);
    // no sub clock or supply pin here: both are taken as ready before every write
    i_table_ptr_low = a;
    wr(OLP_ADDR_DATA_LOW, w[7:0]);
    wr(OLP_ADDR_DATA_HIGH, w[15:8]);
    wr(OLP_ADDR_CTRL, 8'h00);
    wr(OLP_ADDR_CTRL, 8'h08);
    // a clock with no instruction in it must not break the back to back pair
    if (gap) begin
      @(negedge i_clk);
      i_sfr = '0;
      i_instr_cycle = 1'b0;
    end
    wr(OLP_ADDR_CTRL, 8'h0c);
    i_instr_cycle = 1'b1;
    @(negedge i_clk);
    i_sfr = '{1'b0, 1'b1, OLP_ADDR_CTRL, 8'h00};
    i_low_power_entry = lp;
    n = 0;
    @(negedge i_clk);
    while (o_cpu_stall === 1'b1 && n < 50) begin
      n++;
      @(negedge i_clk);
    end
    i_low_power_entry = 1'b0;
    i_sfr = '0;
    `CHK("stall cycles", WC + 1, n)
    `CHK("array addr", pm_addr(a), wa)
    `CHK("array word", w, wd)
    `CHK("write failed", lp, o_write_failed)
    rd_chk(OLP_ADDR_CTRL, 8'h00);
  endtask
  task automatic tread(input logic [7:0] a, input logic [15:0] e);
    i_table_ptr_low = a;
    i_table_read = 1'b1;
    @(negedge i_clk);
    i_table_read = 1'b0;
    n = 0;
    while (o_table_valid !== 1'b1 && n < 20) begin
      n++;
      @(negedge i_clk);
    end
    `CHK("table valid", 1'b1, o_table_valid)
    `CHK("table low", e[7:0], o_table_low_byte)
    `CHK("table high", e[15:8], o_table_high_latch)
  endtask
  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    failures++;
    close_out;
  end
  initial begin
    word = 16'($urandom(30));
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    rd_chk(OLP_ADDR_DATA_LOW, 8'h00);
    rd_chk(OLP_ADDR_DATA_HIGH, 8'h00);
    rd_chk(8'h2f, 8'h00);
    ad = 8'($urandom);
    wr(OLP_ADDR_DATA_HIGH, ad);
    rd_chk(OLP_ADDR_DATA_HIGH, ad);
    w0 = wes;
    wr(OLP_ADDR_CTRL, 8'h00);
    wr(OLP_ADDR_CTRL, 8'h0c);
    wr(OLP_ADDR_CTRL, 8'h00);
    wr(OLP_ADDR_CTRL, 8'h04);
    wr(OLP_ADDR_CTRL, 8'h00);
    wr(OLP_ADDR_CTRL, 8'h08);
    rd_chk(OLP_ADDR_CTRL, 8'h08);
    wr(OLP_ADDR_CTRL, 8'h0c);
    rd_chk(OLP_ADDR_CTRL, 8'h08);
    `CHK("refused writes", w0, wes)
    for (int i = 0; i < 3; i++) begin
      ad = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(80 + $urandom_range(0, 30));
      word = 16'($urandom);
      prog(ad, word, 1'b0, i == 2);
      tread(ad, word);
    end
    prog(8'h10, 16'h1234, 1'b1, 1'b0);
    close_out;
  end
endmodule
